// *** hdl/cei_engine.sv ***
// metering compute engine: sampling, element products, accumulation, data ram
// Functional notes
// - data words are 32-bit two's complement
// - byte address 4*word, MSB first, big-endian
// - host copies calibration into ram before enable
// - sample rate is timebase divided by thirteen
// - accumulation count pre*sum, mirrored at word 0x23
// - interval lasts pre*sum samples
// - host configures everything before setting enable
// - cycles per conversion times conversions equals 12
// - defaults: filter code 0, mux divider 6
// - code 5: three elements VA*IA, VB*IB, VC*IC
// - codes 0 and 1: single element mappings
// - code 2: elements VA*IA and VB*IB
// - code 3: VA*(IA-IB)/2 and VC*IC
// - code 4: VA*(IA-IB)/2 and VB*(IC-IB)/2
// - host selects only equation code 5
// - pass-complete pulse at every sample while the engine runs
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module cei_engine (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   cei_if.engine                   bus,
   input  wire logic signed [15:0] va,
   input  wire logic signed [15:0] vb,
   input  wire logic signed [15:0] vc,
   input  wire logic signed [15:0] ia,
   input  wire logic signed [15:0] ib,
   input  wire logic signed [15:0] ic,
   output logic [31:0]             total_real_energy_sum,
   output logic [31:0]             accumulation_total
);
   logic [9:0]         tb_cnt_reg;
   logic               tb_tick_reg;
   logic [3:0]         frame_cnt_reg;
   logic               smp_tick_reg;
   logic               acc_go_reg;
   logic               running_reg;
   logic [2:0]         equ_reg;
   logic [2:0]         shunt_reg;
   logic [1:0]         fir_reg;
   logic [3:0]         mux_div_reg;
   logic [31:0]        samp_cnt_reg;
   logic signed [15:0] s_v_reg [3];
   logic signed [15:0] s_i_reg [3];
   logic [31:0]        acc_reg [6];
   logic [31:0]        acc_next [6];
   logic [31:0]        term [6];
   logic [31:0]        ram [cei_pkg::RAM_WORDS];
   logic signed [19:0] cur [3];
   logic               start;
   logic               dump;

   assign start = bus.eng_enable & ~running_reg;
   assign dump  = running_reg & acc_go_reg & ((samp_cnt_reg + 32'h1) >= accumulation_total);

   // signed product of voltage and current, low word kept
   function automatic logic [31:0] mul(input logic signed [15:0] v, input logic signed [19:0] i, input logic half);
      logic signed [35:0] p;
      p = 36'(v) * 36'(i);
      if (half)
      begin
         p = p >>> 1;
      end
      mul = p[31:0];
   endfunction : mul

   function automatic logic [31:0] sq(input logic signed [19:0] i);
      logic signed [39:0] p;
      p = 40'(i) * 40'(i);
      sq = p[31:0];
   endfunction : sq

   // 32768 Hz timebase enable
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tb_cnt_reg  <= 10'h000;
         tb_tick_reg <= 1'b0;
      end
      else
      begin
         tb_tick_reg <= (tb_cnt_reg == cei_pkg::TB_DIV_LAST);
         tb_cnt_reg  <= (tb_cnt_reg == cei_pkg::TB_DIV_LAST) ? 10'h000 : tb_cnt_reg + 10'h001;
      end
   end

   // mux frame of thirteen timebase cycles
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         frame_cnt_reg <= 4'h0;
         smp_tick_reg  <= 1'b0;
         acc_go_reg    <= 1'b0;
      end
      else
      begin
         smp_tick_reg <= 1'b0;
         acc_go_reg   <= smp_tick_reg;
         if (tb_tick_reg)
         begin
            if (frame_cnt_reg == cei_pkg::FRAME_TICKS - 4'h1)
            begin
               frame_cnt_reg <= 4'h0;
               smp_tick_reg  <= 1'b1;
            end
            else
            begin
               frame_cnt_reg <= frame_cnt_reg + 4'h1;
            end
         end
      end
   end

   // configuration taken when enable rises; defaults until then
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         running_reg        <= 1'b0;
         equ_reg            <= cei_pkg::EQU_RST;
         shunt_reg          <= 3'h0;
         fir_reg            <= cei_pkg::FIR_RST;
         mux_div_reg        <= cei_pkg::MUX_DIV_RST;
         accumulation_total <= 32'h0000_0000;
      end
      else
      begin
         running_reg <= bus.eng_enable;
         if (start)
         begin
            equ_reg            <= bus.meter_equation_select;
            shunt_reg          <= bus.shunt_sel;
            fir_reg            <= bus.filter_length_code;
            mux_div_reg        <= bus.mux_div;
            accumulation_total <= 32'(bus.pre_sample_count) * 32'(bus.summation_cycle_count);
         end
      end
   end

   // input capture at the end of each frame
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int k = 0; k < 3; k++)
         begin
            s_v_reg[k] <= 16'sh0000;
            s_i_reg[k] <= 16'sh0000;
         end
      end
      else if (smp_tick_reg)
      begin
         s_v_reg[0] <= va;
         s_v_reg[1] <= vb;
         s_v_reg[2] <= vc;
         s_i_reg[0] <= ia;
         s_i_reg[1] <= ib;
         s_i_reg[2] <= ic;
      end
   end

   // shunt gain and element mapping per meter equation
   always_comb
   begin
      for (int k = 0; k < 3; k++)
      begin
         cur[k] = shunt_reg[k] ? (20'(s_i_reg[k]) <<< cei_pkg::SHUNT_SHIFT) : 20'(s_i_reg[k]);
      end
      for (int k = 0; k < 6; k++)
      begin
         term[k] = 32'h0000_0000;
      end
      unique case (equ_reg)
         cei_pkg::EQU_1E_2W:
         begin
            term[0] = mul(s_v_reg[0], cur[0], 1'b0);
            term[3] = sq(cur[0]);
         end
         cei_pkg::EQU_1E_3W:
         begin
            term[0] = mul(s_v_reg[0], cur[0] - cur[1], 1'b1);
            term[3] = sq(cur[0] - cur[1]);
            term[4] = sq(cur[1]);
         end
         cei_pkg::EQU_2E_DELTA3:
         begin
            term[0] = mul(s_v_reg[0], cur[0], 1'b0);
            term[1] = mul(s_v_reg[1], cur[1], 1'b0);
            term[3] = sq(cur[0]);
            term[4] = sq(cur[1]);
         end
         cei_pkg::EQU_2E_DELTA4:
         begin
            term[0] = mul(s_v_reg[0], cur[0] - cur[1], 1'b1);
            term[2] = mul(s_v_reg[2], cur[2], 1'b0);
            term[3] = sq(cur[0] - cur[1]);
            term[4] = sq(cur[1]);
            term[5] = sq(cur[2]);
         end
         cei_pkg::EQU_2E_WYE:
         begin
            term[0] = mul(s_v_reg[0], cur[0] - cur[1], 1'b1);
            term[1] = mul(s_v_reg[1], cur[2] - cur[1], 1'b1);
            term[3] = sq(cur[0] - cur[1]);
            term[4] = sq(cur[2] - cur[1]);
            term[5] = sq(cur[2]);
         end
         cei_pkg::EQU_3E_WYE:
         begin
            for (int k = 0; k < 3; k++)
            begin
               term[k]     = mul(s_v_reg[k], cur[k], 1'b0);
               term[k + 3] = sq(cur[k]);
            end
         end
         default:
         begin
            term[0] = 32'h0000_0000;
         end
      endcase
      for (int k = 0; k < 6; k++)
      begin
         acc_next[k] = acc_reg[k] + term[k];
      end
   end

   // accumulation over pre*sum samples
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         samp_cnt_reg <= 32'h0000_0000;
         for (int k = 0; k < 6; k++)
         begin
            acc_reg[k] <= 32'h0000_0000;
         end
      end
      else if (start || dump)
      begin
         samp_cnt_reg <= 32'h0000_0000;
         for (int k = 0; k < 6; k++)
         begin
            acc_reg[k] <= 32'h0000_0000;
         end
      end
      else if (running_reg && acc_go_reg)
      begin
         samp_cnt_reg <= samp_cnt_reg + 32'h1;
         acc_reg      <= acc_next;
      end
   end

   // data ram: engine results take priority over host byte writes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int k = 0; k < cei_pkg::RAM_WORDS; k++)
         begin
            ram[k] <= 32'h0000_0000;
         end
      end
      else if (dump)
      begin
         ram[cei_pkg::W_TOTAL_REAL_ENERGY_SUM]      <= acc_next[0] + acc_next[1] + acc_next[2];
         ram[cei_pkg::W_ACC_COUNT] <= accumulation_total;
         for (int k = 0; k < 3; k++)
         begin
            ram[cei_pkg::W_W0SUM + 6'(k)]   <= acc_next[k];
            ram[cei_pkg::W_ELEMENT0_CURRENT_SQUARE_SUM + 6'(k)] <= acc_next[k + 3];
         end
      end
      else if (running_reg && acc_go_reg)
      begin
         ram[cei_pkg::W_STATUS] <= {31'h0000_0000, bus.cfg_err};
      end
      else if (bus.ram_we)
      begin
         ram[bus.ram_addr[7:2]][{~bus.ram_addr[1:0], 3'h0} +: 8] <= bus.ram_wdata;
      end
   end

   // link outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus.ram_rdata             <= 8'h00;
         bus.pass_done             <= 1'b0;
         bus.transfer_window_irq   <= 1'b0;
         bus.cfg_err               <= 1'b0;
         bus.running               <= 1'b0;
         total_real_energy_sum     <= 32'h0000_0000;
      end
      else
      begin
         bus.ram_rdata           <= ram[bus.ram_addr[7:2]][{~bus.ram_addr[1:0], 3'h0} +: 8];
         bus.pass_done           <= running_reg & acc_go_reg;
         bus.transfer_window_irq <= dump;
         bus.cfg_err             <= (7'(cei_pkg::conv_cycles(fir_reg)) * 7'(mux_div_reg))
                                    != 7'(cei_pkg::FRAME_BUDGET);
         bus.running             <= running_reg;
         if (dump)
         begin
            total_real_energy_sum <= acc_next[0] + acc_next[1] + acc_next[2];
         end
      end
   end
endmodule : cei_engine

// *** hdl/cei_host.sv ***
// host controller: ahb-lite registers that configure and enable the engine
`timescale 1ns/1ps
module cei_host (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   cei_if.host              bus
);
   logic       wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic       en_req_reg;
   logic       cal_loaded_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;
   logic       cfg_ok;
   logic       wr_go;
   logic       addr_ph;

   assign addr_ph = hsel & htrans[1] & hready;
   assign wr_go   = wr_pend_reg;
   assign cfg_ok  = (7'(cei_pkg::conv_cycles(bus.filter_length_code)) * 7'(bus.mux_div))
                    == 7'(cei_pkg::FRAME_BUDGET);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end
      else
      begin
         wr_pend_reg <= addr_ph & hwrite;
         if (addr_ph)
         begin
            wr_addr_reg <= haddr[7:0];
         end
      end
   end

   // read data registered at the address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (addr_ph && !hwrite)
      begin
         unique case (haddr[7:0])
            cei_pkg::OFS_CTRL:     hrdata <= {25'h0, bus.shunt_sel, bus.meter_equation_select, en_req_reg};
            cei_pkg::OFS_PRE:      hrdata <= {16'h0000, bus.pre_sample_count};
            cei_pkg::OFS_SUM:      hrdata <= {16'h0000, bus.summation_cycle_count};
            cei_pkg::OFS_MUX:      hrdata <= {24'h0, bus.mux_div, 2'h0, bus.filter_length_code};
            cei_pkg::OFS_RAM_ADDR: hrdata <= {24'h0, bus.ram_addr};
            cei_pkg::OFS_RAM_DATA: hrdata <= {24'h0, bus.ram_rdata};
            cei_pkg::OFS_IRQ_STAT: hrdata <= {30'h0, irq_stat_reg};
            cei_pkg::OFS_IRQ_MASK: hrdata <= {30'h0, irq_mask_reg};
            cei_pkg::OFS_STATUS:   hrdata <= {28'h0, cal_loaded_reg, bus.cfg_err, bus.running, bus.eng_enable};
            default:               hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // configuration registers, written in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         en_req_reg                <= 1'b0;
         bus.meter_equation_select                   <= cei_pkg::EQU_RST;
         bus.shunt_sel             <= 3'h0;
         bus.pre_sample_count      <= cei_pkg::PRE_RST;
         bus.summation_cycle_count <= cei_pkg::SUM_RST;
         bus.filter_length_code    <= cei_pkg::FIR_RST;
         bus.mux_div               <= cei_pkg::MUX_DIV_RST;
         bus.ram_addr              <= 8'h00;
         bus.ram_wdata             <= 8'h00;
         bus.ram_we                <= 1'b0;
         cal_loaded_reg            <= 1'b0;
         irq_mask_reg              <= 2'h0;
      end
      else
      begin
         bus.ram_we <= 1'b0;
         if (wr_go)
         begin
            unique case (wr_addr_reg)
               cei_pkg::OFS_CTRL:
               begin
                  en_req_reg    <= hwdata[cei_pkg::CTRL_EN];
                  bus.meter_equation_select       <= hwdata[cei_pkg::CTRL_EQU +: 3];
                  bus.shunt_sel <= hwdata[cei_pkg::CTRL_SHUNT +: 3];
               end
               cei_pkg::OFS_PRE:      bus.pre_sample_count      <= hwdata[15:0];
               cei_pkg::OFS_SUM:      bus.summation_cycle_count <= hwdata[15:0];
               cei_pkg::OFS_MUX:
               begin
                  bus.filter_length_code <= hwdata[cei_pkg::MUX_FIR +: 2];
                  bus.mux_div            <= hwdata[cei_pkg::MUX_DIV +: 4];
               end
               cei_pkg::OFS_RAM_ADDR: bus.ram_addr <= hwdata[7:0];
               cei_pkg::OFS_RAM_DATA:
               begin
                  bus.ram_wdata  <= hwdata[7:0];
                  bus.ram_we     <= 1'b1;
                  cal_loaded_reg <= 1'b1;
               end
               cei_pkg::OFS_IRQ_MASK: irq_mask_reg <= hwdata[1:0];
               default:               en_req_reg   <= en_req_reg;
            endcase
         end
      end
   end

   // enable only with calibration loaded, legal frame budget and equation 5
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus.eng_enable <= 1'b0;
      end
      else
      begin
         bus.eng_enable <= en_req_reg & cal_loaded_reg & cfg_ok & (bus.meter_equation_select == cei_pkg::EQU_3E_WYE);
      end
   end

   // sticky interrupt status, write one to clear, set wins
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_stat_reg <= 2'h0;
         irq          <= 1'b0;
      end
      else
      begin
         irq_stat_reg[cei_pkg::IRQ_PASS] <= bus.pass_done | (irq_stat_reg[cei_pkg::IRQ_PASS]
            & ~(wr_go && wr_addr_reg == cei_pkg::OFS_IRQ_STAT && hwdata[cei_pkg::IRQ_PASS]));
         irq_stat_reg[cei_pkg::IRQ_XFER] <= bus.transfer_window_irq | (irq_stat_reg[cei_pkg::IRQ_XFER]
            & ~(wr_go && wr_addr_reg == cei_pkg::OFS_IRQ_STAT && hwdata[cei_pkg::IRQ_XFER]));
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end
endmodule : cei_host

// *** hdl/cei_if.sv ***
// link between the compute engine and its host controller
`timescale 1ns/1ps
interface cei_if;
   logic        eng_enable;
   logic [2:0]  meter_equation_select;
   logic [15:0] pre_sample_count;
   logic [15:0] summation_cycle_count;
   logic [1:0]  filter_length_code;
   logic [3:0]  mux_div;
   logic [2:0]  shunt_sel;
   logic [7:0]  ram_addr;
   logic [7:0]  ram_wdata;
   logic        ram_we;
   logic [7:0]  ram_rdata;
   logic        pass_done;
   logic        transfer_window_irq;
   logic        cfg_err;
   logic        running;

   modport engine (input  eng_enable, meter_equation_select, pre_sample_count, summation_cycle_count, filter_length_code,
                          mux_div, shunt_sel, ram_addr, ram_wdata, ram_we,
                   output ram_rdata, pass_done, transfer_window_irq, cfg_err, running);
   modport host   (output eng_enable, meter_equation_select, pre_sample_count, summation_cycle_count, filter_length_code,
                          mux_div, shunt_sel, ram_addr, ram_wdata, ram_we,
                   input  ram_rdata, pass_done, transfer_window_irq, cfg_err, running);
endinterface : cei_if

// *** hdl/cei_pkg.sv ***
// shared constants for the compute engine and its host controller
package cei_pkg;
   // clocking
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned TB_HZ           = 32768;
   localparam int unsigned TB_DIV          = (CLK_HZ + TB_HZ / 2) / TB_HZ;
   localparam logic [9:0]  TB_DIV_LAST     = 10'(TB_DIV - 1);
   localparam logic [3:0]  FRAME_TICKS     = 4'hd;
   localparam logic [4:0]  FRAME_BUDGET    = 5'h0c;
   // engine data ram
   localparam int unsigned RAM_WORDS       = 64;
   localparam logic [5:0]  W_ACC_COUNT     = 6'h23;
   localparam logic [5:0]  W_TOTAL_REAL_ENERGY_SUM          = 6'h28;
   localparam logic [5:0]  W_W0SUM         = 6'h29;
   localparam logic [5:0]  W_ELEMENT0_CURRENT_SQUARE_SUM       = 6'h2c;
   localparam logic [5:0]  W_STATUS        = 6'h2f;
   // meter equation codes
   localparam logic [2:0]  EQU_1E_2W       = 3'h0;
   localparam logic [2:0]  EQU_1E_3W       = 3'h1;
   localparam logic [2:0]  EQU_2E_DELTA3   = 3'h2;
   localparam logic [2:0]  EQU_2E_DELTA4   = 3'h3;
   localparam logic [2:0]  EQU_2E_WYE      = 3'h4;
   localparam logic [2:0]  EQU_3E_WYE      = 3'h5;
   // shunt gain shift (gain 8)
   localparam int unsigned SHUNT_SHIFT     = 3;
   // reset values
   localparam logic [2:0]  EQU_RST         = 3'h5;
   localparam logic [15:0] PRE_RST         = 16'h002a;
   localparam logic [15:0] SUM_RST         = 16'h003c;
   localparam logic [1:0]  FIR_RST         = 2'h0;
   localparam logic [3:0]  MUX_DIV_RST     = 4'h6;
   // host register offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_PRE         = 8'h04;
   localparam logic [7:0]  OFS_SUM         = 8'h08;
   localparam logic [7:0]  OFS_MUX         = 8'h0c;
   localparam logic [7:0]  OFS_RAM_ADDR    = 8'h10;
   localparam logic [7:0]  OFS_RAM_DATA    = 8'h14;
   localparam logic [7:0]  OFS_IRQ_STAT    = 8'h18;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h1c;
   localparam logic [7:0]  OFS_STATUS      = 8'h20;
   // field positions
   localparam int unsigned CTRL_EN         = 0;
   localparam int unsigned CTRL_EQU        = 1;
   localparam int unsigned CTRL_SHUNT      = 4;
   localparam int unsigned MUX_FIR         = 0;
   localparam int unsigned MUX_DIV         = 4;
   localparam int unsigned IRQ_PASS        = 0;
   localparam int unsigned IRQ_XFER        = 1;

   // timebase cycles per conversion for a filter length code
   function automatic logic [4:0] conv_cycles(input logic [1:0] code);
      conv_cycles = 5'(code) + 5'h02;
   endfunction : conv_cycles
endpackage : cei_pkg

// *** tb/cei_monitor.sv ***
// concurrent checks on the engine to host link
`timescale 1ns/1ps
module cei_monitor (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        eng_enable,
   input wire logic [2:0]  meter_equation_select,
   input wire logic [15:0] pre_sample_count,
   input wire logic [15:0] summation_cycle_count,
   input wire logic [1:0]  filter_length_code,
   input wire logic [3:0]  mux_div,
   input wire logic        pass_done,
   input wire logic        transfer_window_irq,
   input wire logic        running
);
   localparam int SAMPLE_CLKS = int'(cei_pkg::TB_DIV) * 13;
   logic [15:0] gap_reg;
   logic        seen_reg;
   logic [31:0] samples_reg;
   logic [31:0] target_reg;

   default clocking mon_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // clocks since the last sample pulse
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         gap_reg <= 16'h0000;
      else
         gap_reg <= pass_done ? 16'h0000 : gap_reg + 16'h0001;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         seen_reg <= 1'b0;
      else
         seen_reg <= running & (seen_reg | pass_done);
   end

   // samples in the current interval
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         samples_reg <= 32'h0;
         target_reg  <= 32'h0;
      end
      else if ($rose(eng_enable))
      begin
         samples_reg <= 32'h0;
         target_reg  <= 32'(pre_sample_count) * 32'(summation_cycle_count);
      end
      else if (transfer_window_irq)
         samples_reg <= 32'h0;
      else if (pass_done)
         samples_reg <= samples_reg + 32'h1;
   end

   sequence start_s;
      ##[1:3] running;
   endsequence
   sequence stop_s;
      ##[1:3] !running;
   endsequence

   defaults_reset_a: assert property ($rose(hresetn) |-> filter_length_code == 2'h0 && mux_div == 4'h6)
      else $error("link defaults wrong after reset");
   idle_quiet_a: assert property (!eng_enable && !running |-> !pass_done && !transfer_window_irq)
      else $error("engine active while disabled");
   pass_pulse_a: assert property (pass_done |=> !pass_done)
      else $error("pass pulse longer than one cycle");
   sample_rate_a: assert property (pass_done && seen_reg |-> gap_reg == 16'(SAMPLE_CLKS - 1))
      else $error("sample spacing wrong");
   interval_len_a: assert property (transfer_window_irq |-> samples_reg + 32'(pass_done) == target_reg)
      else $error("interval length wrong");
   start_run_a: assert property ($rose(eng_enable) |-> start_s)
      else $error("engine did not start");
   stop_run_a: assert property ($fell(eng_enable) |-> stop_s)
      else $error("engine did not stop");
   enable_gate_a: assert property ($rose(eng_enable) |-> meter_equation_select == 3'h5)
      else $error("enabled with unsupported equation");
endmodule : cei_monitor

// *** tb/tb_compute_engine_interface.sv ***
// register level test of host controller and compute engine
`timescale 1ns/1ps
module tb_compute_engine_interface;
   logic               hclk;
   logic               hresetn;
   logic               hsel;
   logic [31:0]        haddr;
   logic [1:0]         htrans;
   logic               hwrite;
   logic [2:0]         hsize;
   logic [31:0]        hwdata;
   logic [31:0]        hrdata;
   logic               hready;
   logic               hresp;
   logic               irq;
   logic signed [15:0] va, vb, vc, ia, ib, ic;
   logic [31:0]        sum_out;
   logic [31:0]        acc_out;
   logic [31:0]        rd;
   int                 fail_count;
   int                 checks_done;
   int                 expect_sum;
   logic [7:0]         rofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c, 8'h20, 8'h40};
   logic [31:0]        rexp [8] = '{32'h0a, 32'h2a, 32'h3c, 32'h60, 32'h0, 32'h0, 32'h0, 32'h0};

   cei_if link ();
   cei_host u_cei_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .irq(irq), .bus(link.host));
   cei_engine u_cei_engine (.hclk(hclk), .hresetn(hresetn), .bus(link.engine), .va(va), .vb(vb), .vc(vc),
      .ia(ia), .ib(ib), .ic(ic), .total_real_energy_sum(sum_out), .accumulation_total(acc_out));
   cei_monitor u_cei_monitor (.hclk(hclk), .hresetn(hresetn), .eng_enable(link.eng_enable), .meter_equation_select(link.meter_equation_select),
      .pre_sample_count(link.pre_sample_count), .summation_cycle_count(link.summation_cycle_count),
      .filter_length_code(link.filter_length_code), .mux_div(link.mux_div), .pass_done(link.pass_done),
      .transfer_window_irq(link.transfer_window_irq), .running(link.running));

   always #20 hclk = ~hclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one single word transfer
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb

   // engine word through the byte window, most significant byte first
   task automatic rword(input logic [5:0] w, input logic [31:0] exp);
      logic [31:0] q;
      for (int k = 0; k < 4; k++)
      begin
         ahb(1'b1, cei_pkg::OFS_RAM_ADDR, {24'h0, w, 2'(k)});
         repeat (2) @(posedge hclk);
         ahb(1'b0, cei_pkg::OFS_RAM_DATA, 32'h0);
         q = {q[23:0], rd[7:0]};
      end
      chk(q, exp);
   endtask : rword

   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim)
      begin
         @(posedge hclk);
         n++;
      end
   endtask : wait_irq

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   initial
   begin
      repeat (90000) @(posedge hclk);
      fail_count++;
      give_verdict();
   end

   initial
   begin
      hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
      va = -16'sd3; vb = 16'sd5; vc = 16'sd7; ia = 16'sd100; ib = -16'sd20; ic = 16'sd3;
      expect_sum = 2 * (va * ia * 8 + vb * ib + vc * ic);
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         ahb(1'b0, rofs[i], 32'h0);
         chk(rd, rexp[i]);
      end
      $display("test reset values done");
      for (int k = 0; k < 4; k++)
      begin
         ahb(1'b1, cei_pkg::OFS_RAM_ADDR, 32'h80 + k);
         ahb(1'b1, cei_pkg::OFS_RAM_DATA, 32'h50 + k);
      end
      rword(6'h20, 32'h50515253);
      ahb(1'b1, cei_pkg::OFS_PRE, 32'h1);
      ahb(1'b1, cei_pkg::OFS_SUM, 32'h2);
      ahb(1'b1, cei_pkg::OFS_CTRL, 32'h05);
      repeat (10100) @(posedge hclk);
      ahb(1'b0, cei_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h8);
      ahb(1'b0, cei_pkg::OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h0);
      $display("test refused enable done");
      ahb(1'b1, cei_pkg::OFS_IRQ_MASK, 32'h1);
      ahb(1'b1, cei_pkg::OFS_MUX, 32'hb2);
      ahb(1'b1, cei_pkg::OFS_CTRL, 32'h1b);
      ahb(1'b0, cei_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h8);
      ahb(1'b1, cei_pkg::OFS_MUX, 32'h60);
      wait_irq(11000);
      chk({31'h0, irq}, 32'h1);
      ahb(1'b0, cei_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'hb);
      ahb(1'b1, cei_pkg::OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      ahb(1'b1, cei_pkg::OFS_IRQ_MASK, 32'h2);
      wait_irq(25000);
      chk({31'h0, irq}, 32'h1);
      chk(acc_out, 32'h2);
      chk(sum_out, 32'(expect_sum));
      repeat (50) @(posedge hclk);
      rword(6'h23, 32'h2);
      rword(6'h28, 32'(expect_sum));
      $display("test run and interval done");
      ahb(1'b1, cei_pkg::OFS_CTRL, 32'h0a);
      ahb(1'b1, cei_pkg::OFS_IRQ_MASK, 32'h3);
      ahb(1'b1, cei_pkg::OFS_IRQ_STAT, 32'h3);
      repeat (10100) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      ahb(1'b0, cei_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h8);
      $display("test disable done");
      give_verdict();
   end
endmodule : tb_compute_engine_interface
